// ---- src/hk_adc_params.svh ----
`ifndef HK_ADC_PARAMS_SVH
`define HK_ADC_PARAMS_SVH
// ==========================================================================
// register indices; byte address is four times the index
`define HK_IDX_RESULT 16'h402D
`define HK_IDX_CONTROL 16'h402E
`define HK_IDX_SOURCES 16'h402F
// ==========================================================================
// control register fields
`define HK_CTL_POWER_BIT 15
`define HK_CTL_GO_BIT 14
`define HK_CTL_SLEEP_BIT 12
`define HK_RATE_MSB 5
`define HK_RATE_MANUAL 6'h00
`define HK_RATE_RESERVED 6'h20
`define HK_RATE_FAST_BASE 6'h20
`define HK_SLOW_STEP 10'h002
`define HK_FAST_STEP 10'h010
// ==========================================================================
// source enables and result fields
`define HK_SOURCE_COUNT 10
`define HK_TAG_MSB 15
`define HK_TAG_LSB 12
`define HK_CODE_MSB 11
`define HK_REG_RESET 16'h0000
// ==========================================================================
// timing: ref_clk rate in Hz
`define HK_CLK_HZ 20000000
`endif

// ---- src/hk_adc_pkg.sv ----
package hk_adc_pkg;
  // ==========================================================================
  // result word: tag and code always move together
  typedef struct packed {
    logic [3:0] tag;
    logic [11:0] code;
  } result_t;

  typedef struct packed {
    logic converter_power_on;
    logic conversion_go;
    logic sleep_enable;
    logic [5:0] rate;
  } control_t;

  // request to the analogue converter
  typedef struct packed {
    logic start;
    logic [3:0] tag;
  } conv_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } state_t;
endpackage

// ---- src/housekeeping_adc_sequencer.sv ----
`timescale 1ns/1ns
`include "hk_adc_params.svh"
module housekeeping_adc_sequencer #(
  parameter int CLK_HZ = `HK_CLK_HZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output hk_adc_pkg::conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic [11:0] conv_code,
  output logic converter_power_on,
  output logic result_event
);
  localparam int PW = $clog2(CLK_HZ) + 1;
  localparam logic [PW-1:0] CLK_HZ_W = PW'(CLK_HZ);
  localparam int NS = `HK_SOURCE_COUNT;

  // ==========================================================================
  // decode helpers
  function automatic logic [9:0] rate_to_sps(input logic [5:0] rate);
    logic [9:0] sps;
    sps = 10'h000;
    if (rate == `HK_RATE_MANUAL || rate == `HK_RATE_RESERVED) begin
      sps = 10'h000;
    end else if (rate < `HK_RATE_FAST_BASE) begin
      sps = 10'(rate) * `HK_SLOW_STEP;
    end else begin
      sps = 10'(rate - `HK_RATE_FAST_BASE) * `HK_FAST_STEP;
    end
    return sps;
  endfunction

  // round robin from the bit after the last one measured
  function automatic logic [3:0] next_source(input logic [NS-1:0] mask,
                                             input logic [3:0] last);
    logic [3:0] pick;
    logic found;
    int idx;
    pick = last;
    found = 1'b0;
    for (int i = 1; i <= NS; i++) begin
      idx = (int'(last) + i) % NS;
      if (!found && mask[idx]) begin
        pick = 4'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] val;
    val = old;
    if (sel[0]) begin
      val[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      val[15:8] = dat[15:8];
    end
    return val;
  endfunction

  // ==========================================================================
  // state
  hk_adc_pkg::control_t ctl;
  hk_adc_pkg::result_t result;
  hk_adc_pkg::state_t state;
  logic [NS-1:0] sources;
  logic [3:0] last_idx;
  logic [3:0] conv_tag;
  logic [PW-1:0] phase;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // wishbone slave: one wait state, unmapped reads zero, writes dropped
  // a write lands on the edge at which the master samples ack, never earlier
  wire [15:0] reg_index = wb_adr_i[17:2];
  wire upper_zero = (wb_adr_i[31:18] == 14'h0000) && (wb_adr_i[1:0] == 2'b00);
  wire hit_result = upper_zero && (reg_index == `HK_IDX_RESULT);
  wire hit_control = upper_zero && (reg_index == `HK_IDX_CONTROL);
  wire hit_sources = upper_zero && (reg_index == `HK_IDX_SOURCES);
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  wire wr_control = bus_wr && hit_control;
  wire wr_sources = bus_wr && hit_sources;

  wire [15:0] control_word = {ctl.converter_power_on, ctl.conversion_go, 1'b0,
                              ctl.sleep_enable, 6'h00, ctl.rate};
  wire [15:0] sources_word = {6'h00, sources};
  wire [15:0] control_new = merge16(control_word, wb_dat_i, wb_sel_i);
  wire [15:0] sources_new = merge16(sources_word, wb_dat_i, wb_sel_i);
  wire [15:0] read_word = hit_result ? result :
                          hit_control ? control_word :
                          hit_sources ? sources_word : `HK_REG_RESET;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= {16'h0000, read_word};
    end
  end

  // ==========================================================================
  // free-running timebase: phase accumulator steps by samples per second
  wire [9:0] sps = rate_to_sps(ctl.rate);
  wire [PW-1:0] phase_sum = phase + PW'(sps);
  wire tick = (sps != 10'h000) && (phase_sum >= CLK_HZ_W);
  wire [PW-1:0] next_phase = tick ? phase_sum - CLK_HZ_W : phase_sum;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

  // ==========================================================================
  // trigger and sequencing
  wire manual_mode = (ctl.rate == `HK_RATE_MANUAL);
  wire any_source = (sources != '0);
  wire idle = (state == hk_adc_pkg::ST_IDLE);
  wire armed = ctl.converter_power_on && ctl.conversion_go && any_source && idle;
  // an automatic tick during a conversion is dropped, not queued
  wire fire = armed && (manual_mode || tick);
  wire [3:0] pick = next_source(sources, last_idx);
  wire done_accept = (state == hk_adc_pkg::ST_CONVERT) && conv_done;
  wire abort = (state == hk_adc_pkg::ST_CONVERT) && !ctl.converter_power_on;
  wire manual_clear = done_accept && manual_mode;

  hk_adc_pkg::state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      hk_adc_pkg::ST_IDLE: begin
        if (fire) begin
          next_state = hk_adc_pkg::ST_CONVERT;
        end
      end
      hk_adc_pkg::ST_CONVERT: begin
        if (done_accept || abort) begin
          next_state = hk_adc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = hk_adc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= hk_adc_pkg::ST_IDLE;
      last_idx <= 4'(NS - 1);
      conv_tag <= 4'h0;
      conv_req <= '0;
    end else begin
      state <= next_state;
      conv_req.start <= fire;
      if (fire) begin
        last_idx <= pick;
        conv_tag <= pick + 4'h1;
        conv_req.tag <= pick + 4'h1;
      end
    end
  end

  // ==========================================================================
  // registers written by software; a software write beats the auto-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl <= '0;
      sources <= '0;
    end else begin
      if (wr_control) begin
        ctl.converter_power_on <= control_new[`HK_CTL_POWER_BIT];
        ctl.conversion_go <= control_new[`HK_CTL_GO_BIT];
        ctl.sleep_enable <= control_new[`HK_CTL_SLEEP_BIT];
        ctl.rate <= control_new[`HK_RATE_MSB:0];
      end else if (manual_clear) begin
        ctl.conversion_go <= 1'b0;
      end
      if (wr_sources) begin
        sources <= sources_new[NS-1:0];
      end
    end
  end

  // ==========================================================================
  // result register: overwritten whole, never queued
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result <= '0;
      result_event <= 1'b0;
    end else begin
      result_event <= done_accept;
      if (done_accept) begin
        result <= {conv_tag, conv_code};
      end
    end
  end

  assign converter_power_on = ctl.converter_power_on;

  // ==========================================================================
  // checks
  sequence seq_done;
    state == hk_adc_pkg::ST_CONVERT && conv_done;
  endsequence

  sequence seq_update;
    result_event && result.tag == $past(conv_tag) && result.code == $past(conv_code);
  endsequence

  AST_RATE_SLOW: assert property (
    (ctl.rate > 6'h00 && ctl.rate < 6'h20) |-> sps == 10'(ctl.rate) * 10'h002)
    else $error("slow rate decode wrong");

  AST_RATE_FAST: assert property (
    (ctl.rate > 6'h20) |-> sps == 10'(ctl.rate - 6'h20) * 10'h010)
    else $error("fast rate decode wrong");

  AST_RESERVED_SILENT: assert property (
    (ctl.rate == 6'h20 || sources == '0) |=> !conv_req.start)
    else $error("trigger with reserved rate or no source");

  AST_SOURCES_WRITE: assert property (
    (wr_sources && wb_sel_i[1:0] == 2'b11) |=> sources == $past(wb_dat_i[9:0]))
    else $error("source enables not stored");

  AST_SOURCES_READ: assert property (
    (bus_req && !wb_we_i && hit_sources) |=> wb_dat_o[31:10] == 22'h000000)
    else $error("source register upper bits not zero");

  AST_RESULT_UPDATE: assert property (
    seq_done |=> seq_update)
    else $error("result not updated from converter");

  AST_TAG_ENABLED: assert property (
    conv_req.start |-> conv_req.tag >= 4'h1 && conv_req.tag <= 4'hA
                       && ((($past(sources) >> (conv_req.tag - 4'h1)) & 10'h001) != 10'h000))
    else $error("tag out of range or source not enabled");

  AST_EVENT_CAUSE: assert property (
    result_event |-> $past(done_accept) && result.tag != 4'h0)
    else $error("event without a result write");

  AST_MANUAL_CLEAR: assert property (
    (manual_clear && !wr_control) |=> !ctl.conversion_go ##1 idle)
    else $error("manual go bit not cleared");

  AST_ONE_PER_TRIGGER: assert property (
    conv_req.start |-> !idle ##1 (!conv_req.start))
    else $error("second start during a conversion");

  AST_AUTO_GATED: assert property (
    conv_req.start |-> $past(ctl.converter_power_on && ctl.conversion_go))
    else $error("start while disabled");

  AST_RESULT_HOLD: assert property (
    !done_accept |=> $stable(result))
    else $error("result changed without a finished conversion");

  AST_EVENT_PULSE: assert property (
    result_event |=> !result_event)
    else $error("result event longer than one cycle");

  AST_UNPOWERED_QUIET: assert property (
    !ctl.converter_power_on |=> !conv_req.start)
    else $error("start while converter powered down");
endmodule // housekeeping_adc_sequencer

// ---- verification/test_housekeeping_adc_sequencer.sv ----
`timescale 1ns/1ns
`include "hk_adc_params.svh"
module test_housekeeping_adc_sequencer;
  // ==========================================================================
  // clock, reset and bench state
  // small timebase keeps the slowest rate at a few hundred cycles a tick
  localparam int CLK = 1000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  hk_adc_pkg::conv_req_t conv_req;
  logic conv_done = 1'b0;
  logic [11:0] conv_code = 12'h000;
  logic [11:0] code_val = 12'h000;
  logic converter_power_on;
  logic result_event;
  logic [15:0] rd;
  logic [3:0] last_tag = 4'h0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_starts = 0;
  int n_events = 0;
  int last_start = 0;
  int last_gap = 0;
  int wait_cnt = 0;

  always #25 ref_clk = ~ref_clk;

  housekeeping_adc_sequencer #(.CLK_HZ(CLK)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conv_req(conv_req), .conv_done(conv_done), .conv_code(conv_code),
    .converter_power_on(converter_power_on), .result_event(result_event)
  );

  // ==========================================================================
  // converter stand-in: answers every start three cycles later
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    conv_done <= 1'b0;
    if (result_event === 1'b1) n_events <= n_events + 1;
    if (conv_req.start === 1'b1) begin
      n_starts <= n_starts + 1;
      last_gap <= cyc - last_start;
      last_start <= cyc;
      last_tag <= conv_req.tag;
      wait_cnt <= 3;
    end else if (wait_cnt == 1) begin
      conv_done <= 1'b1;
      conv_code <= code_val;
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end

  // ==========================================================================
  // tasks
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wb(input logic we, input logic [15:0] idx, input logic [15:0] wd,
          output logic [15:0] rdat);
    int n;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {14'h0, idx, 2'b00};
    wb_sel <= 4'h3;
    wb_dat_i <= {16'h0, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check("bus ack", 1'b0, 1'b1);
    rdat = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task manual(input logic [3:0] etag);
    int s0;
    int e0;
    int k;
    s0 = n_starts;
    e0 = n_events;
    code_val = {3{etag}};
    wb(1'b1, `HK_IDX_CONTROL, 16'hC000, rd);
    k = 0;
    while (n_events == e0 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    check("power pin", converter_power_on, 1'b1);
    check("one start", n_starts, s0 + 1);
    check("tag", last_tag, etag);
    wb(1'b0, `HK_IDX_RESULT, 16'h0, rd);
    check("result", rd, {etag, code_val});
    wb(1'b0, `HK_IDX_CONTROL, 16'h0, rd);
    check("go cleared", rd, 16'h8000);
  endtask

  task auto_gap(input logic [5:0] rate);
    int sps;
    int n0;
    int k;
    sps = (rate < 6'd32) ? 2 * rate : 16 * (rate - 32);
    wb(1'b1, `HK_IDX_CONTROL, {10'h300, rate}, rd);
    n0 = n_starts;
    k = 0;
    while (n_starts < n0 + 3 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    check("three starts", n_starts >= n0 + 3, 1'b1);
    check("tick gap", last_gap >= CLK / sps && last_gap <= CLK / sps + 1, 1'b1);
    wb(1'b1, `HK_IDX_CONTROL, 16'h8000, rd);
    repeat (10) @(posedge ref_clk);
  endtask

  task no_start(input logic [15:0] src, input logic [15:0] ctl);
    int n0;
    wb(1'b1, `HK_IDX_SOURCES, src, rd);
    wb(1'b1, `HK_IDX_CONTROL, ctl, rd);
    n0 = n_starts;
    repeat (300) @(posedge ref_clk);
    check("idle starts", n_starts, n0);
    wb(1'b1, `HK_IDX_CONTROL, 16'h0000, rd);
  endtask

  task end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  logic [3:0] tags2 [4] = '{4'h1, 4'h5, 4'hA, 4'h1};
  logic [5:0] rates [5] = '{6'h01, 6'h03, 6'h1F, 6'h21, 6'h28};

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, `HK_IDX_RESULT, 16'h0, rd);
    check("result reset", rd, 16'h0000);
    wb(1'b0, `HK_IDX_SOURCES, 16'h0, rd);
    check("sources reset", rd, 16'h0000);
    wb(1'b1, `HK_IDX_SOURCES, 16'h03FF, rd);
    wb(1'b0, `HK_IDX_SOURCES, 16'h0, rd);
    check("sources", rd, 16'h03FF);
    for (int i = 1; i <= 10; i++) manual(i[3:0]);
    wb(1'b1, `HK_IDX_SOURCES, 16'h0211, rd);
    for (int i = 0; i < 4; i++) manual(tags2[i]);
    check("events", n_events, n_starts);
    // result is read-only; unmapped space reads zero
    wb(1'b1, `HK_IDX_RESULT, 16'hFFFF, rd);
    wb(1'b0, `HK_IDX_RESULT, 16'h0, rd);
    check("result ro", rd, 16'h1111);
    wb(1'b1, 16'h4030, 16'hFFFF, rd);
    wb(1'b0, 16'h4030, 16'h0, rd);
    check("unmapped", rd, 16'h0000);
    no_start(16'h03FF, 16'hC020);
    no_start(16'h0000, 16'hC021);
    no_start(16'h03FF, 16'h4021);
    wb(1'b1, `HK_IDX_SOURCES, 16'h03FF, rd);
    for (int i = 0; i < 5; i++) auto_gap(rates[i]);
    end_of_test();
  end

  initial begin
    #2000000;
    fails++;
    end_of_test();
  end
endmodule // test_housekeeping_adc_sequencer
